// ==== src/acc_load_consts.svh ====
// Constants for the accumulator-load execution block
`ifndef ACC_LOAD_CONSTS_SVH
`define ACC_LOAD_CONSTS_SVH

`define INSTR_W             10
`define NIB_W               4
`define OP_RAM_PREFIX       6'h2c
`define OP_RAM_PREFIX_MSB   9
`define OP_RAM_PREFIX_LSB   4
`define OP_CLOCK_CTRL       10'h252
`define OP_PULLUP_ZERO      10'h257
`define OP_PULLUP_ONE       10'h25e
`define NIB_RESET           4'h0

`endif

// ==== src/acc_load_pkg.sv ====
// Types for the accumulator-load execution block
`include "acc_load_consts.svh"

package acc_load_pkg;

  typedef logic [`NIB_W-1:0]   nibble_type;
  typedef logic [`INSTR_W-1:0] instr_type;

  typedef enum logic [2:0] {
    OP_NONE       = 3'h0,
    OP_RAM        = 3'h1,
    OP_CLOCK_CTRL = 3'h3,
    OP_PULLUP0    = 3'h2,
    OP_PULLUP1    = 3'h6
  } op_type;

  typedef struct packed {
    nibble_type ram_word;
    nibble_type row_reg;
    nibble_type clock_control_reg;
    nibble_type pullup_ctrl_zero;
    nibble_type pullup_ctrl_one;
  } sources_type;

  typedef struct packed {
    logic       acc_we;
    nibble_type acc_data;
    logic       row_we;
    nibble_type row_data;
    logic       carry_we;
    logic       skip;
    logic       done;
  } state_type;

endpackage : acc_load_pkg

// ==== src/accumulator_load_instr.sv ====
// Execution of the accumulator-load instruction group
// Overview of operation
// - The RAM load instruction copies the RAM word at the data pointer into the accumulator.
// - The RAM load instruction also replaces the row register with its XOR against the 4-bit immediate.
// - The clock-control read (opcode 0x252) copies the clock control register into the accumulator.
// - The first pull-up read (opcode 0x257) copies the first pull-up control register into the accumulator.
// - The second pull-up read (opcode 0x25e) copies the second pull-up control register into the accumulator.
`timescale 1ns/1ps
`include "acc_load_consts.svh"

module accumulator_load_instr
  import acc_load_pkg::*;
(
  input  wire logic        i_clk,
  input  wire logic        i_reset,
  input  wire logic        i_instr_valid,
  input  wire instr_type   i_instr,
  input  wire sources_type i_src,
  output logic             o_acc_we,
  output nibble_type       o_acc_data,
  output logic             o_row_we,
  output nibble_type       o_row_data,
  output logic             o_carry_we,
  output logic             o_skip,
  output logic             o_done
);

  state_type state_r;
  state_type state_nxt;
  op_type    op;

  // Opcode decode
  function automatic op_type decode_op(input instr_type instr);
    if (instr[`OP_RAM_PREFIX_MSB:`OP_RAM_PREFIX_LSB] == `OP_RAM_PREFIX) begin
      decode_op = OP_RAM;
    end else if (instr == `OP_CLOCK_CTRL) begin
      decode_op = OP_CLOCK_CTRL;
    end else if (instr == `OP_PULLUP_ZERO) begin
      decode_op = OP_PULLUP0;
    end else if (instr == `OP_PULLUP_ONE) begin
      decode_op = OP_PULLUP1;
    end else begin
      decode_op = OP_NONE;
    end
  endfunction : decode_op

  always_comb begin
    op = i_instr_valid ? decode_op(i_instr) : OP_NONE;
    state_nxt          = state_r;
    state_nxt.acc_we   = 1'b0;
    state_nxt.row_we   = 1'b0;
    state_nxt.carry_we = 1'b0;
    state_nxt.skip     = 1'b0;
    state_nxt.done     = 1'b0;
    case (op)
      OP_RAM: begin
        state_nxt.acc_we   = 1'b1;
        state_nxt.acc_data = i_src.ram_word;
        state_nxt.row_we   = 1'b1;
        state_nxt.row_data = i_src.row_reg ^ i_instr[`NIB_W-1:0];
        state_nxt.done     = 1'b1;
      end
      OP_CLOCK_CTRL: begin
        state_nxt.acc_we   = 1'b1;
        state_nxt.acc_data = i_src.clock_control_reg;
        state_nxt.done     = 1'b1;
      end
      OP_PULLUP0: begin
        state_nxt.acc_we   = 1'b1;
        state_nxt.acc_data = i_src.pullup_ctrl_zero;
        state_nxt.done     = 1'b1;
      end
      OP_PULLUP1: begin
        state_nxt.acc_we   = 1'b1;
        state_nxt.acc_data = i_src.pullup_ctrl_one;
        state_nxt.done     = 1'b1;
      end
      default: begin
        state_nxt.done = 1'b0;
      end
    endcase
  end

  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      state_r <= '{acc_we:   1'b0,
                   acc_data: `NIB_RESET,
                   row_we:   1'b0,
                   row_data: `NIB_RESET,
                   carry_we: 1'b0,
                   skip:     1'b0,
                   done:     1'b0};
    end else begin
      state_r <= state_nxt;
    end
  end

  assign o_acc_we   = state_r.acc_we;
  assign o_acc_data = state_r.acc_data;
  assign o_row_we   = state_r.row_we;
  assign o_row_data = state_r.row_data;
  assign o_carry_we = state_r.carry_we;
  assign o_skip     = state_r.skip;
  assign o_done     = state_r.done;

  // Checks
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (i_reset);

  AST_RAM_TO_ACC: assert property (
    i_instr_valid
      && decode_op(i_instr) == OP_RAM
      |=> o_acc_we
      && o_acc_data == $past(i_src.ram_word))
    else $error("RAM load did not reach the accumulator");

  AST_ACC_HOLDS: assert property (
    !o_acc_we
      |-> $stable(o_acc_data))
    else $error("Accumulator data moved without a write");

  AST_ROW_XOR: assert property (
    i_instr_valid
      && decode_op(i_instr) == OP_RAM
      |=> o_row_we
      && o_row_data == ($past(i_src.row_reg) ^ $past(i_instr[3:0])))
    else $error("Row register XOR update wrong");

  AST_ROW_ONLY_RAM: assert property (
    o_row_we
      |-> $past(i_instr_valid)
      && $past(decode_op(i_instr)) == OP_RAM)
    else $error("Row register written without RAM load");

  AST_ROW_HOLDS: assert property (
    !o_row_we
      |-> $stable(o_row_data))
    else $error("Row data moved without a write");

  AST_CLOCK_CTRL: assert property (
    i_instr_valid
      && i_instr == `OP_CLOCK_CTRL
      |=> o_acc_we
      && !o_row_we
      && o_acc_data == $past(i_src.clock_control_reg))
    else $error("Clock control read wrong");

  AST_PULLUP_ZERO: assert property (
    i_instr_valid
      && i_instr == `OP_PULLUP_ZERO
      |=> o_acc_we
      && !o_row_we
      && o_acc_data == $past(i_src.pullup_ctrl_zero))
    else $error("First pull-up read wrong");

  AST_PULLUP_ONE: assert property (
    i_instr_valid
      && i_instr == `OP_PULLUP_ONE
      |=> o_acc_we
      && !o_row_we
      && o_acc_data == $past(i_src.pullup_ctrl_one))
    else $error("Second pull-up read wrong");

  AST_NO_CARRY_SKIP: assert property (
    !o_carry_we
      && !o_skip)
    else $error("Carry or skip touched");

  AST_ONE_CYCLE: assert property (
    o_done
      |-> o_acc_we
      && $past(i_instr_valid)
      && $past(decode_op(i_instr)) != OP_NONE)
    else $error("Completion not in one cycle");

  AST_DONE_EACH_WORD: assert property (
    i_instr_valid
      && decode_op(i_instr) != OP_NONE
      |=> o_done
      && o_acc_we)
    else $error("Group instruction did not complete");

  AST_REFUSED_QUIET: assert property (
    !(i_instr_valid && decode_op(i_instr) != OP_NONE)
      |=> !o_done
      && !o_acc_we
      && !o_row_we)
    else $error("Pulse without a group instruction");

  AST_RESET_CLEARS: assert property (
    disable iff (1'b0)
    $past(i_reset)
      |-> !o_acc_we
      && !o_row_we
      && !o_done
      && o_acc_data == `NIB_RESET
      && o_row_data == `NIB_RESET)
    else $error("Outputs not cleared by reset");

  // Main scenarios
  COV_RAM: cover property (
    i_instr_valid && decode_op(i_instr) == OP_RAM ##1 o_row_we);
  COV_CLOCK: cover property (
    i_instr_valid && i_instr == `OP_CLOCK_CTRL ##1 o_done);
  COV_PULLUP_ONE: cover property (
    i_instr_valid && i_instr == `OP_PULLUP_ONE ##1 o_done);
  COV_BACK_TO_BACK: cover property (
    o_done ##1 o_done ##1 o_done);

endmodule : accumulator_load_instr

// ==== tb/tb_top.sv ====
// Self-checking bench for the accumulator-load execution block
`timescale 1ns/1ps
`include "acc_load_consts.svh"
module tb_top;
  import acc_load_pkg::*;
  logic        i_clk;
  logic        i_reset;
  logic        i_instr_valid;
  instr_type   i_instr;
  sources_type i_src;
  logic        o_acc_we;
  nibble_type  o_acc_data;
  logic        o_row_we;
  nibble_type  o_row_data;
  logic        o_carry_we;
  logic        o_skip;
  logic        o_done;
  int          n_errors;
  int          cmp_count;
  logic        ew;
  logic        rw;
  nibble_type  ea;
  nibble_type  er;
  accumulator_load_instr accumulator_load_instr_inst (.i_clk(i_clk), .i_reset(i_reset),
    .i_instr_valid(i_instr_valid), .i_instr(i_instr), .i_src(i_src), .o_acc_we(o_acc_we),
    .o_acc_data(o_acc_data), .o_row_we(o_row_we), .o_row_data(o_row_data),
    .o_carry_we(o_carry_we), .o_skip(o_skip), .o_done(o_done));
  initial begin
    i_clk = 1'b0;
    forever #50 i_clk = ~i_clk;
  end
  task check(input logic [9:0] seen, input logic [9:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      n_errors++;
      $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : check
  // Drives one word, judges the word driven one cycle earlier
  task step(input logic v, input instr_type ins, input sources_type s, input logic nw,
            input nibble_type na, input logic nr, input nibble_type nrd);
    @(posedge i_clk);
    i_instr_valid <= v;
    i_instr       <= ins;
    i_src         <= s;
    @(negedge i_clk);
    check({o_acc_we, o_acc_data, o_row_we, o_row_data}, {ew, ea, rw, er});
    check({7'h0, o_carry_we, o_skip, o_done}, {9'h0, ew});
    ew = nw;
    rw = nr;
    if (nw) ea = na;
    if (nr) er = nrd;
  endtask : step
  // Every immediate, back to back
  task test_ram_load;
    for (int j = 0; j < 16; j++) begin
      step(1'b1, {`OP_RAM_PREFIX, 4'(j)}, {4'(15 - j), 4'(j + 5), 12'h9ac}, 1'b1, 4'(15 - j),
           1'b1, 4'(j + 5) ^ 4'(j));
    end
  endtask : test_ram_load
  // Reset in mid-run overrides a word in flight and clears every output
  task test_reset;
    @(posedge i_clk);
    i_reset       <= 1'b1;
    i_instr_valid <= 1'b1;
    i_instr       <= {`OP_RAM_PREFIX, 4'h3};
    i_src         <= 20'hfffff;
    @(negedge i_clk);
    check({o_acc_we, o_acc_data, o_row_we, o_row_data}, {ew, ea, rw, er});
    @(negedge i_clk);
    check({o_acc_we, o_acc_data, o_row_we, o_row_data}, 10'h0);
    check({7'h0, o_carry_we, o_skip, o_done}, 10'h0);
    @(posedge i_clk);
    i_reset       <= 1'b0;
    i_instr_valid <= 1'b0;
    ew = 1'b0;
    rw = 1'b0;
    ea = 4'h0;
    er = 4'h0;
  endtask : test_reset
  // Each register read picks its own source
  task test_reads;
    step(1'b1, `OP_CLOCK_CTRL, 20'h129ac, 1'b1, 4'h9, 1'b0, 4'h0);
    step(1'b1, `OP_PULLUP_ZERO, 20'h129ac, 1'b1, 4'ha, 1'b0, 4'h0);
    step(1'b1, `OP_PULLUP_ONE, 20'h129ac, 1'b1, 4'hc, 1'b0, 4'h0);
  endtask : test_reads
  // Invalid cycles and neighbouring opcodes give no pulses
  task test_refused;
    instr_type bad [5];
    bad = '{10'h253, 10'h25f, 10'h256, 10'h2d0, 10'h3c5};
    step(1'b0, `OP_PULLUP_ZERO, 20'h129ac, 1'b0, 4'h0, 1'b0, 4'h0);
    foreach (bad[k]) begin
      step(1'b1, bad[k], 20'h129ac, 1'b0, 4'h0, 1'b0, 4'h0);
    end
    step(1'b0, 10'h0, 20'h0, 1'b0, 4'h0, 1'b0, 4'h0);
  endtask : test_refused
  task final_report;
    if (n_errors == 0 && cmp_count > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask : final_report
  initial begin
    n_errors      = 0;
    cmp_count     = 0;
    ew            = 1'b0;
    rw            = 1'b0;
    ea            = 4'h0;
    er            = 4'h0;
    i_reset       = 1'b1;
    i_instr_valid = 1'b0;
    i_instr       = 10'h0;
    i_src         = 20'h0;
    repeat (4) @(posedge i_clk);
    i_reset <= 1'b0;
    test_ram_load();
    test_reset();
    test_reads();
    test_refused();
    final_report();
  end
  initial begin
    repeat (300) @(posedge i_clk);
    n_errors++;
    final_report();
  end
endmodule : tb_top
